// *** csio_params.svh ***
`ifndef CSIO_PARAMS_SVH
`define CSIO_PARAMS_SVH
// Register offsets
`define CSIO_A_CTL1 4'h0
`define CSIO_A_CTL2 4'h1
`define CSIO_A_STAT 4'h2
`define CSIO_A_BUF_BIT 3
// serial_control_one fields
`define CSIO_RUN_BIT 7
`define CSIO_ABORT_BIT 6
`define CSIO_MODE_MSB 5
`define CSIO_MODE_LSB 3
`define CSIO_CLK_MSB 2
`define CSIO_CLK_LSB 0
// serial_control_two fields
`define CSIO_DIVSEL_BIT 7
`define CSIO_CNT_MSB 2
`define CSIO_CNT_LSB 0
// serial_status_reg fields
`define CSIO_ST_ACTIVE 0
`define CSIO_ST_SHIFT 1
// Clock source codes
`define CSIO_CLK_EXT 3'h7
`define CSIO_CLK_SLOW 3'h0
// Half periods of the internal serial clock, in clk_i cycles or slow ticks
`define CSIO_HALF_0 12'h800
`define CSIO_HALF_0_SLOW 12'h010
`define CSIO_HALF_1 12'h080
`define CSIO_HALF_2 12'h040
`define CSIO_HALF_3 12'h020
`define CSIO_HALF_4 12'h010
`define CSIO_HALF_5 12'h008
// Word shape
`define CSIO_LAST_BIT8 3'h7
`define CSIO_LAST_BIT4 3'h3
`define CSIO_DUMMY 8'hff
`define CSIO_RESET_MODE 3'h0
`endif

// *** csio_pkg.sv ***
package csio_pkg;
  typedef enum logic [2:0] {
    CSIO_TX8 = 3'b000,
    CSIO_TX4 = 3'b010,
    CSIO_TRX8 = 3'b100,
    CSIO_RX8 = 3'b101,
    CSIO_RX4 = 3'b110
  } csio_mode_t;
  typedef enum logic [1:0] {
    CSIO_IDLE = 2'b00,
    CSIO_SHIFT = 2'b01,
    CSIO_HOLD = 2'b10
  } csio_state_t;
endpackage

// *** csio_top.sv ***
`timescale 1ns/1ps
`include "csio_params.svh"

module csio_top
  import csio_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic si_i,
  output logic so_o,
  // Slow clock tick and completion event
  input wire logic lf_tick_i,
  output logic serial_done_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic run_r;
  logic divsel_r;
  csio_mode_t mode_r;
  logic [2:0] clksel_r;
  logic [2:0] cnt_r;
  csio_state_t state_r;
  logic [7:0] buf_r [DEPTH];
  logic [7:0] txsh_r;
  logic [7:0] rxsh_r;
  logic [2:0] bit_r;
  logic [2:0] widx_r;
  logic svc_r;
  logic dummy_r;
  logic sck_r;
  logic so_r;
  logic sckprev_r;
  logic irq_r;
  logic [11:0] div_r;
  logic [7:0] rdata_r;
  logic [11:0] half;

  wire ext = clksel_r == `CSIO_CLK_EXT;
  wire is_tx = mode_r == CSIO_TX8 || mode_r == CSIO_TX4 || mode_r == CSIO_TRX8;
  wire is_rx = mode_r == CSIO_TRX8 || mode_r == CSIO_RX8 || mode_r == CSIO_RX4;
  wire four = mode_r == CSIO_TX4 || mode_r == CSIO_RX4;
  wire wr_c1 = wr_i && addr_i == `CSIO_A_CTL1;
  wire wr_c2 = wr_i && addr_i == `CSIO_A_CTL2;
  wire wr_buf = wr_i && addr_i[`CSIO_A_BUF_BIT];
  wire rd_buf = rd_i && addr_i[`CSIO_A_BUF_BIT];
  wire abort = wr_c1 && wdata_i[`CSIO_ABORT_BIT];
  wire start = state_r == CSIO_IDLE && wr_c1 && wdata_i[`CSIO_RUN_BIT] && !abort;
  wire [2:0] new_mode = wdata_i[`CSIO_MODE_MSB:`CSIO_MODE_LSB];
  // Any entry counts, even one outside the word range
  wire svc_set = (wr_buf && is_tx) || (rd_buf && !is_tx);
  wire [2:0] last_bit = four ? `CSIO_LAST_BIT4 : `CSIO_LAST_BIT8;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock source
  always_comb
  begin
    unique case (clksel_r)
      3'h0: half = divsel_r ? `CSIO_HALF_0_SLOW : `CSIO_HALF_0;
      3'h1: half = `CSIO_HALF_1;
      3'h2: half = `CSIO_HALF_2;
      3'h3: half = `CSIO_HALF_3;
      3'h4: half = `CSIO_HALF_4;
      3'h5: half = `CSIO_HALF_5;
      default: half = `CSIO_HALF_5;
    endcase
  end

  wire tick = (clksel_r == `CSIO_CLK_SLOW && divsel_r) ? lf_tick_i : 1'b1;
  wire running = state_r == CSIO_SHIFT && !ext;
  wire div_hit = running && tick && div_r == half - 12'h001;
  // Pin is taken as synchronous; wide external pulses keep one event per edge
  wire ext_on = ext && state_r == CSIO_SHIFT;
  wire fall_ev = ext ? (ext_on && sckprev_r && !sck_i) : (div_hit && sck_r);
  wire rise_ev = ext ? (ext_on && !sckprev_r && sck_i) : (div_hit && !sck_r);
  wire word_end = rise_ev && bit_r == last_bit;
  wire blk_end = word_end && widx_r == cnt_r;
  wire blk_start_fall = fall_ev && bit_r == 3'h0 && widx_r == 3'h0;
  wire ext_dummy = ext && is_tx && blk_start_fall && !svc_r;
  wire rx_cancel = word_end && is_rx && ext && widx_r == 3'h0 && !svc_r;
  wire rx_store = word_end && is_rx && !rx_cancel;
  wire finish = word_end && ((!run_r && (!is_tx || widx_r == cnt_r)) || dummy_r || rx_cancel);
  wire [7:0] rx_word = four ? {4'h0, si_i, rxsh_r[7:5]} : {si_i, rxsh_r[7:1]};
  wire [7:0] tx_src = ext_dummy ? `CSIO_DUMMY : buf_r[widx_r];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_r <= 12'h000;
      sck_r <= 1'b1;
    end
    else if (!running)
    begin
      div_r <= 12'h000;
      sck_r <= 1'b1;
    end
    else if (tick)
    begin
      if (div_hit)
      begin
        div_r <= 12'h000;
        sck_r <= !sck_r;
      end
      else
      begin
        div_r <= div_r + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sckprev_r <= 1'b1;
    else
      sckprev_r <= sck_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_r <= 1'b0;
      mode_r <= CSIO_TX8;
      clksel_r <= 3'h0;
    end
    else if (wr_c1)
    begin
      run_r <= wdata_i[`CSIO_RUN_BIT] && !abort;
      mode_r <= csio_mode_t'(new_mode);
      clksel_r <= wdata_i[`CSIO_CLK_MSB:`CSIO_CLK_LSB];
    end
    else if (finish)
    begin
      run_r <= 1'b0;
    end
  end

  // Count may change anytime; a stop first is software's duty
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      divsel_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else if (wr_c2)
    begin
      divsel_r <= wdata_i[`CSIO_DIVSEL_BIT];
      cnt_r <= wdata_i[`CSIO_CNT_MSB:`CSIO_CNT_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_r <= CSIO_IDLE;
    else if (abort)
      state_r <= CSIO_IDLE;
    else
    begin
      unique case (state_r)
        CSIO_IDLE:
          if (start)
            state_r <= CSIO_SHIFT;
        CSIO_SHIFT:
          if (finish)
            state_r <= CSIO_IDLE;
          else if (blk_end && !ext && !(svc_r || svc_set))
            state_r <= CSIO_HOLD;
        CSIO_HOLD:
          if (!run_r)
            state_r <= CSIO_IDLE;
          else if (svc_r)
            state_r <= CSIO_SHIFT;
        default:
          state_r <= CSIO_IDLE;
      endcase
    end
  end

  // Service seen since the last block end; a new event beats the clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      svc_r <= 1'b0;
    else if (start)
      // Internal: preloaded data is this block, so a wait still needs fresh service
      svc_r <= wdata_i[`CSIO_CLK_MSB:`CSIO_CLK_LSB] == `CSIO_CLK_EXT;
    else
      svc_r <= svc_set || (svc_r && !blk_end && state_r != CSIO_HOLD);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_r <= 3'h0;
      widx_r <= 3'h0;
    end
    else if (state_r == CSIO_IDLE)
    begin
      bit_r <= 3'h0;
      widx_r <= 3'h0;
    end
    else if (rise_ev)
    begin
      if (bit_r == last_bit)
      begin
        bit_r <= 3'h0;
        widx_r <= (widx_r == cnt_r) ? 3'h0 : widx_r + 3'h1;
      end
      else
      begin
        bit_r <= bit_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift paths
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      so_r <= 1'b1;
      txsh_r <= 8'h00;
    end
    else if (state_r == CSIO_IDLE)
    begin
      so_r <= 1'b1;
    end
    else if (fall_ev && is_tx)
    begin
      if (bit_r == 3'h0)
      begin
        so_r <= tx_src[0];
        txsh_r <= {1'b0, tx_src[7:1]};
      end
      else
      begin
        so_r <= txsh_r[0];
        txsh_r <= {1'b0, txsh_r[7:1]};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dummy_r <= 1'b0;
    else if (state_r == CSIO_IDLE)
      dummy_r <= 1'b0;
    else if (ext_dummy)
      dummy_r <= 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rxsh_r <= 8'h00;
    else if (rise_ev && is_rx)
      rxsh_r <= {si_i, rxsh_r[7:1]};
  end

  // Buffer entries; mode change wipes them, received words beat software
  generate
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          buf_r[i] <= 8'h00;
        else if (wr_c1 && new_mode != mode_r)
          buf_r[i] <= 8'h00;
        else if (rx_store && widx_r == 3'(i))
          buf_r[i] <= rx_word;
        else if (wr_buf && addr_i[2:0] == 3'(i))
          buf_r[i] <= wdata_i;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Completion event and read port
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else
      irq_r <= blk_end && !rx_cancel;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_r <= 8'h00;
    else if (rd_i && addr_i == `CSIO_A_STAT)
      rdata_r <= {6'h00, state_r == CSIO_SHIFT, state_r != CSIO_IDLE};
    else if (rd_buf)
      rdata_r <= buf_r[addr_i[2:0]];
    else
      rdata_r <= 8'h00;
  end

  assign rdata_o = rdata_r;
  assign sck_o = sck_r;
  assign sck_oe_n_o = ext;
  assign so_o = so_r;
  assign serial_done_irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ext_release_pin: assert property (ext |-> sck_oe_n_o && sck_o)
    else $error("clock pin driven with external source");
  a_start_sck_high: assert property (start && !ext |=> sck_o && !sck_oe_n_o)
    else $error("clock pin not high at transfer start");
  a_so_on_fall: assert property (state_r != CSIO_IDLE && !ext && $changed(so_o) |-> $fell(sck_o))
    else $error("data out changed off the falling edge");
  a_rx_nibble_zero: assert property (rx_store && four |=> buf_r[$past(widx_r)][7:4] == 4'h0)
    else $error("upper nibble not cleared in four-bit receive");
  a_word_index: assert property (state_r != CSIO_IDLE && !wr_c2 |-> widx_r <= cnt_r)
    else $error("word index beyond programmed count");
  a_irq_count: assert property (serial_done_irq_o |-> $past(widx_r) == $past(cnt_r) && $past(word_end))
    else $error("completion raised at wrong word");
  a_wait_clock_stop: assert property (state_r == CSIO_HOLD ##1 state_r == CSIO_HOLD |-> sck_o && $stable(div_r))
    else $error("clock moved during automatic wait");
  a_abort_idle: assert property (abort |=> state_r == CSIO_IDLE ##1 rdata_r[0] == 1'b0 || !$past(rd_i))
    else $error("abort did not stop the transfer");
  a_mode_wipe: assert property (wr_c1 && new_mode != mode_r |=> buf_r[0] == 8'h00 && buf_r[DEPTH-1] == 8'h00)
    else $error("buffer kept across mode change");

endmodule

// *** csio_peer.sv ***
`timescale 1ns/1ps

module csio_peer
(
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic sck_pin_i,
  input wire logic so_i,
  output logic si_o,
  output logic sck_drv_o
);
  logic [7:0] rx_sh;
  logic [15:0] tx_sh;
  initial
  begin
    rx_sh = 8'h00;
    tx_sh = 16'h0000;
    si_o = 1'b1;
    sck_drv_o = 1'b1;
  end
  ////////////////////////////////////////
  // Capture on the rising pin edge
  always @(posedge sck_pin_i)
  begin
    rx_sh = {so_i, rx_sh[7:1]};
    #8;
    // Hold over, so no stale bit lingers
    si_o = ~si_o;
  end
  // New bit on the falling pin edge
  always @(negedge sck_pin_i)
  begin
    si_o = tx_sh[0];
    tx_sh = {1'b0, tx_sh[15:1]};
  end
  // Clock stays high between frames
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      sck_drv_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      sck_drv_o <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule

// *** tb_clocked_serial_io.sv ***
`timescale 1ns/1ps
`include "csio_params.svh"

`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_clocked_serial_io import csio_pkg::*;;
  logic clk_i, rst_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic sck_o, sck_oe_n_o, so_o, serial_done_irq_o;
  wire logic si_w, sck_drv, sck_pin;
  logic lf_tick;
  int n_mismatch, cmp_count;
  // Whoever has the enable owns the clock pin
  assign sck_pin = sck_oe_n_o ? sck_drv : sck_o;
  csio_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
    .si_i(si_w), .so_o(so_o), .lf_tick_i(lf_tick), .serial_done_irq_o(serial_done_irq_o));
  csio_peer u_peer (.clk_i(clk_i), .sck_pin_i(sck_pin), .so_i(so_o), .si_o(si_w), .sck_drv_o(sck_drv));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Slow tick every other cycle, so the divided rate differs from the fast one
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      lf_tick <= 1'b0;
    else
      lf_tick <= !lf_tick;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(nm, exp, rdata_o)
  endtask
  task automatic ctl(input logic run, input logic abrt, input csio_mode_t m, input logic [2:0] src);
    wr(`CSIO_A_CTL1, {run, abrt, m, src});
  endtask
  // Bounded wait for the done pulse
  task automatic wait_irq();
    int i;
    i = 0;
    while (serial_done_irq_o !== 1'b1 && i < 3000)
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    `CHK("done pulse", 1'b1, serial_done_irq_o)
    if (serial_done_irq_o !== 1'b1)
      close_out();
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("sck idle", 1'b1, sck_o)
    `CHK("so idle", 1'b1, so_o)
    rd(`CSIO_A_STAT, 8'h00, "status");
    rd(4'h3, 8'h00, "unmapped");
    // Internal transmit, one word, then auto wait
    wr(`CSIO_A_CTL2, 8'h00);
    ctl(1'b0, 1'b1, CSIO_TX8, 3'h5);
    wr(4'h8, 8'ha5);
    ctl(1'b1, 1'b0, CSIO_TX8, 3'h5);
    #1;
    `CHK("pin driven", 1'b0, sck_oe_n_o)
    `CHK("sck at start", 1'b1, sck_o)
    wait_irq();
    `CHK("tx word", 8'ha5, u_peer.rx_sh)
    rd(`CSIO_A_STAT, 8'h01, "tx wait");
    wr(4'hf, 8'h77);
    wait_irq();
    ctl(1'b0, 1'b0, CSIO_TX8, 3'h5);
    rd(`CSIO_A_STAT, 8'h00, "run cleared");
    // Two nibbles back to back
    wr(`CSIO_A_CTL2, 8'h01);
    ctl(1'b0, 1'b1, CSIO_TX4, 3'h5);
    wr(4'h8, 8'hf6);
    wr(4'h9, 8'h09);
    ctl(1'b1, 1'b0, CSIO_TX4, 3'h5);
    wait_irq();
    `CHK("tx nibbles", 8'h96, u_peer.rx_sh)
    ctl(1'b0, 1'b1, CSIO_RX8, 3'h5);
    rd(`CSIO_A_STAT, 8'h00, "tx abort");
    // Abort in mid word while receiving
    ctl(1'b1, 1'b0, CSIO_RX8, 3'h5);
    repeat (40) @(posedge clk_i);
    ctl(1'b0, 1'b1, CSIO_RX8, 3'h5);
    rd(`CSIO_A_STAT, 8'h00, "rx abort");
    u_peer.tx_sh = 16'hc381;
    ctl(1'b1, 1'b0, CSIO_RX8, 3'h5);
    wait_irq();
    rd(`CSIO_A_STAT, 8'h01, "rx wait");
    rd(4'h8, 8'h81, "rx word 0");
    rd(4'h9, 8'hc3, "rx word 1");
    ctl(1'b0, 1'b1, CSIO_RX4, 3'h5);
    wr(`CSIO_A_CTL2, 8'h00);
    u_peer.tx_sh = 16'h00ab;
    ctl(1'b1, 1'b0, CSIO_RX4, 3'h5);
    wait_irq();
    rd(4'h8, 8'h0b, "rx nibble");
    ctl(1'b0, 1'b1, CSIO_TX8, 3'h5);
    rd(4'h8, 8'h00, "mode switch");
    // External clock transmit, then dummy frame
    ctl(1'b0, 1'b1, CSIO_TX8, 3'h7);
    wr(4'h8, 8'h4e);
    ctl(1'b1, 1'b0, CSIO_TX8, 3'h7);
    #1;
    `CHK("pin released", 1'b1, sck_oe_n_o)
    u_peer.pulses(8);
    `CHK("ext tx", 8'h4e, u_peer.rx_sh)
    u_peer.pulses(8);
    `CHK("dummy", `CSIO_DUMMY, u_peer.rx_sh)
    rd(`CSIO_A_STAT, 8'h00, "dummy end");
    // External receive with unread data
    ctl(1'b0, 1'b1, CSIO_RX8, 3'h7);
    u_peer.tx_sh = 16'h5b3c;
    ctl(1'b1, 1'b0, CSIO_RX8, 3'h7);
    u_peer.pulses(16);
    rd(`CSIO_A_STAT, 8'h00, "rx cancel");
    rd(4'h8, 8'h3c, "first kept");
    // Slow ticked source, both directions at once
    ctl(1'b0, 1'b1, CSIO_TRX8, 3'h0);
    wr(`CSIO_A_CTL2, 8'h80);
    wr(4'h8, 8'h3a);
    u_peer.tx_sh = 16'h00c5;
    ctl(1'b1, 1'b0, CSIO_TRX8, 3'h0);
    repeat (24) @(posedge clk_i);
    #1;
    `CHK("slow sck high", 1'b1, sck_o)
    repeat (20) @(posedge clk_i);
    #1;
    `CHK("slow sck low", 1'b0, sck_o)
    wait_irq();
    `CHK("trx out", 8'h3a, u_peer.rx_sh)
    rd(4'h8, 8'hc5, "trx in");
    rd(`CSIO_A_STAT, 8'h01, "trx wait");
    close_out();
  end
endmodule
